// [rwd_pkg.sv]
package rwd_pkg;
    // register addresses
    localparam logic [7:0] ADDR_CENTURY = 8'h03;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_WDOG = 8'h09;
    localparam logic [7:0] ADDR_ALARM_MONTH = 8'h0A;
    localparam logic [7:0] ADDR_FLAGS = 8'h0F;
    localparam logic [7:0] ADDR_WAVE = 8'h13;
    localparam logic [7:0] ADDR_HALT = 8'h01;
    localparam logic [7:0] ADDR_ALARM_HOUR = 8'h0C;
    // field positions
    localparam int CEN_ENABLE_BIT = 7;
    localparam int CEN_BIT = 6;
    localparam int CTL_OUT_BIT = 7;
    localparam int CTL_FT_BIT = 6;
    localparam int AM_AFE_BIT = 7;
    localparam int AM_SQUARE_WAVE_ENABLE_BIT = 6;
    localparam int AM_ABE_BIT = 5;
    localparam int FLG_WDF_BIT = 7;
    localparam int FLG_AF_BIT = 6;
    localparam int HALT_OSC_BIT = 7;
    localparam int HOUR_FREEZE_BIT = 6;
    localparam int WAVE_RS_LSB = 4;
    localparam int WD_MULT_LSB = 2;
    // reset values on first power-up
    localparam logic [7:0] RST_CONTROL = 8'h80;
    localparam logic [7:0] RST_WDOG = 8'h00;
    localparam logic [7:0] RST_ALARM_MONTH = 8'h00;
    localparam logic [7:0] RST_HALT = 8'h80;
    localparam logic [7:0] RST_HOUR = 8'h40;
    // timebase: oscillator tick counts
    localparam int OSC_HZ = 32768;
    localparam int SYS_HZ = 100000000;
    localparam int DIV_W = 15;
    localparam int FT_DIV_BIT = 5;
    // 1/16 s tick is bit 11 of the oscillator divider, ticks per resolution unit
    localparam logic [7:0] RES_TICKS_0 = 8'h01;
    localparam logic [7:0] RES_TICKS_1 = 8'h04;
    localparam logic [7:0] RES_TICKS_2 = 8'h10;
    localparam logic [7:0] RES_TICKS_3 = 8'h40;
    localparam int SIXTEENTH_BIT = 11;
endpackage

// [rwd_reg_mem.sv]
`timescale 1ns/10ps
// small register store with registered read data
module rwd_reg_mem #(
    parameter int AW = 5,
    parameter int DW = 8
) (
    // clock
    input wire logic sys_clk,
    // write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // read side
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem_ff [0:(1<<AW)-1];
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
        rd_data <= mem_ff[rd_addr];
    end
endmodule

// [rwd_watchdog_top.sv]
`timescale 1ns/10ps
module rwd_watchdog_top
    import rwd_pkg::*;
(
    // system
    input wire logic sys_clk,
    input wire logic rst,
    // power state: first power-up versus retained backup
    input wire logic backup_valid,
    // 32768 Hz oscillator, asynchronous
    input wire logic osc_clk,
    // register port from the serial engine
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // events from the timekeeping core
    input wire logic century_rollover,
    input wire logic alarm_match,
    // multi-function pin, open drain
    input wire logic multi_function_pin_in,
    output logic multi_function_pin_out,
    output logic multi_function_pin_oe
);
    import rwd_pkg::*;

    // oscillator synchroniser; first stage read only by second
    logic osc_s1_ff, osc_s2_ff, osc_s3_ff;
    logic osc_tick;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            osc_s3_ff <= 1'b0;
        end else begin
            osc_s1_ff <= osc_clk;
            osc_s2_ff <= osc_s1_ff;
            osc_s3_ff <= osc_s2_ff;
        end
    end
    assign osc_tick = osc_s2_ff & ~osc_s3_ff;

    // registers held in flops because they steer logic
    logic [7:0] century_ff, control_ff, wdog_ff, alarm_ff, halt_ff, hour_ff, wave_ff;
    logic [7:0] nxt_century, nxt_control, nxt_wdog, nxt_alarm, nxt_halt, nxt_hour, nxt_wave;
    logic wdf_ff, af_ff, nxt_wdf, nxt_af;
    logic [DIV_W-1:0] div_ff, nxt_div;
    logic [12:0] wd_cnt_ff, nxt_wd_cnt;
    logic wd_run_ff, nxt_wd_run;
    logic pin_low_ff, nxt_pin_low;
    logic [7:0] rdata_ff, nxt_rdata;
    logic init_ff, nxt_init;
    logic [1:0] flag_view_ff, nxt_flag_view;

    logic pin_sync1_ff, pin_sync2_ff;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_sync1_ff <= 1'b0;
            pin_sync2_ff <= 1'b0;
        end else begin
            pin_sync1_ff <= multi_function_pin_in;
            pin_sync2_ff <= pin_sync1_ff;
        end
    end

    // plain storage for the rest of the map
    logic [7:0] mem_rdata;
    logic [7:0] rd_addr_q_ff;
    rwd_reg_mem #(.AW(5), .DW(8)) u_mem (
        .sys_clk(sys_clk),
        .wr_en(reg_wr),
        .wr_addr(reg_addr[4:0]),
        .wr_data(reg_wdata),
        .rd_addr(reg_addr[4:0]),
        .rd_data(mem_rdata)
    );

    function automatic logic [7:0] res_ticks(input logic [1:0] rb);
        logic [7:0] t;
        t = RES_TICKS_0;
        unique case (rb)
            2'b00: t = RES_TICKS_0;
            2'b01: t = RES_TICKS_1;
            2'b10: t = RES_TICKS_2;
            2'b11: t = RES_TICKS_3;
        endcase
        return t;
    endfunction

    // divider tap for a square-wave rate code
    function automatic logic wave_bit(input logic [3:0] rs, input logic [DIV_W-1:0] d,
                                      input logic osc);
        logic w;
        w = 1'b0;
        if (rs == 4'h1) begin
            w = osc;
        end else if (rs != 4'h0) begin
            w = d[rs - 4'h1];
        end
        return w;
    endfunction

    logic [3:0] rate_sel;
    logic square_wave_enable, afe, ft, out_lvl, wd_prog, sixteenth_tick, osc_running;
    logic wave_lvl, ft_lvl;
    assign rate_sel = wave_ff[WAVE_RS_LSB +: 4];
    assign square_wave_enable = alarm_ff[AM_SQUARE_WAVE_ENABLE_BIT];
    assign afe = alarm_ff[AM_AFE_BIT];
    assign ft = control_ff[CTL_FT_BIT];
    assign out_lvl = control_ff[CTL_OUT_BIT];
    assign wd_prog = (wdog_ff != 8'h00);
    assign osc_running = ~halt_ff[HALT_OSC_BIT];
    assign sixteenth_tick = osc_tick && (div_ff[SIXTEENTH_BIT-1:0] == '1);
    assign wave_lvl = wave_bit(rate_sel, div_ff, osc_s3_ff);
    assign ft_lvl = div_ff[FT_DIV_BIT];

    logic wr_wdog, rd_flags;
    assign wr_wdog = reg_wr && (reg_addr == ADDR_WDOG);
    assign rd_flags = reg_rd && (reg_addr == ADDR_FLAGS);

    always_comb begin
        nxt_century = century_ff;
        nxt_control = control_ff;
        nxt_wdog = wdog_ff;
        nxt_alarm = alarm_ff;
        nxt_halt = halt_ff;
        nxt_hour = hour_ff;
        nxt_wave = wave_ff;
        nxt_wdf = wdf_ff;
        nxt_af = af_ff;
        nxt_div = div_ff;
        nxt_wd_cnt = wd_cnt_ff;
        nxt_wd_run = wd_run_ff;
        nxt_init = 1'b0;
        if (osc_tick) begin
            nxt_div = div_ff + 1'b1;
        end
        if (init_ff) begin
            nxt_hour[HOUR_FREEZE_BIT] = 1'b1;
            nxt_control[CTL_FT_BIT] = 1'b0;
            nxt_wdog = RST_WDOG;
            if (!backup_valid) begin
                nxt_control = RST_CONTROL;
                nxt_alarm = RST_ALARM_MONTH;
                nxt_halt = RST_HALT;
                nxt_hour = RST_HOUR;
                nxt_century = 8'h00;
                nxt_wave = 8'h00;
            end
        end else if (reg_wr) begin
            unique case (reg_addr)
                ADDR_CENTURY: nxt_century = reg_wdata;
                ADDR_CONTROL: nxt_control = reg_wdata;
                ADDR_WDOG: nxt_wdog = reg_wdata;
                ADDR_ALARM_MONTH: nxt_alarm = reg_wdata;
                ADDR_HALT: nxt_halt = reg_wdata;
                ADDR_ALARM_HOUR: nxt_hour = reg_wdata;
                ADDR_WAVE: nxt_wave = {reg_wdata[7:4], 4'h0};
                default: ;
            endcase
        end
        if (century_rollover && century_ff[CEN_ENABLE_BIT] &&
            !(reg_wr && reg_addr == ADDR_CENTURY)) begin
            nxt_century[CEN_BIT] = ~century_ff[CEN_BIT];
        end
        if (rd_flags) begin
            nxt_wdf = 1'b0;
            nxt_af = 1'b0;
        end
        if (alarm_match) begin
            nxt_af = 1'b1;
        end
        if (wr_wdog) begin
            nxt_wd_cnt = 13'(reg_wdata[WD_MULT_LSB +: 5] * res_ticks(reg_wdata[1:0]));
            nxt_wd_run = (reg_wdata[WD_MULT_LSB +: 5] != 5'h00);
        end else if (wd_run_ff && sixteenth_tick) begin
            if (wd_cnt_ff <= 13'h0001) begin
                nxt_wd_cnt = 13'h0000;
                nxt_wd_run = 1'b0;
                nxt_wdf = 1'b1;
            end else begin
                nxt_wd_cnt = wd_cnt_ff - 13'h0001;
            end
        end
        if (init_ff) begin
            nxt_wd_run = 1'b0;
            nxt_wd_cnt = 13'h0000;
        end
    end

    // pin source priority
    logic wd_irq_ff, nxt_wd_irq;
    always_comb begin
        nxt_wd_irq = wd_irq_ff;
        if (wd_run_ff && sixteenth_tick && wd_cnt_ff <= 13'h0001 && !wr_wdog) begin
            nxt_wd_irq = 1'b1;
        end
        if ((wr_wdog && reg_wdata == 8'h00) || init_ff) begin
            nxt_wd_irq = 1'b0;
        end
        nxt_pin_low = 1'b0;
        if (square_wave_enable && rate_sel != 4'h0) begin
            nxt_pin_low = ~wave_lvl;
        end else if (afe && !square_wave_enable) begin
            nxt_pin_low = af_ff;
        end else if (wd_prog) begin
            nxt_pin_low = wd_irq_ff;
        end else if (ft && !square_wave_enable) begin
            nxt_pin_low = osc_running ? ~ft_lvl : 1'b0;
        end else if (!square_wave_enable) begin
            nxt_pin_low = ~out_lvl;
        end
        // backed-up controls are stale until the init cycle has run
        if (init_ff) begin
            nxt_pin_low = 1'b0;
        end
        // flags sampled for read before the clear lands
        nxt_flag_view = {wdf_ff, af_ff};
        if (!rd_flags && reg_addr == ADDR_FLAGS) begin
            // hold while the pointer rests on the flags so the clear stays unseen
            nxt_flag_view = flag_view_ff;
        end
        nxt_rdata = mem_rdata;
        unique case (rd_addr_q_ff)
            ADDR_CENTURY: nxt_rdata = century_ff;
            ADDR_CONTROL: nxt_rdata = control_ff;
            ADDR_WDOG: nxt_rdata = wdog_ff;
            ADDR_ALARM_MONTH: nxt_rdata = alarm_ff;
            ADDR_HALT: nxt_rdata = halt_ff;
            ADDR_ALARM_HOUR: nxt_rdata = hour_ff;
            ADDR_WAVE: nxt_rdata = wave_ff;
            ADDR_FLAGS: nxt_rdata = {flag_view_ff, 6'h00};
            default: nxt_rdata = (rd_addr_q_ff > 8'h13) ? 8'h00 : mem_rdata;
        endcase
    end

    // state that a power loss clears
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wdog_ff <= RST_WDOG;
            wdf_ff <= 1'b0;
            af_ff <= 1'b0;
            div_ff <= '0;
            wd_cnt_ff <= 13'h0000;
            wd_run_ff <= 1'b0;
            wd_irq_ff <= 1'b0;
            pin_low_ff <= 1'b0;
            rdata_ff <= 8'h00;
            rd_addr_q_ff <= 8'h00;
            flag_view_ff <= 2'b00;
            init_ff <= 1'b1;
        end else begin
            wdog_ff <= nxt_wdog;
            wdf_ff <= nxt_wdf;
            af_ff <= nxt_af;
            div_ff <= nxt_div;
            wd_cnt_ff <= nxt_wd_cnt;
            wd_run_ff <= nxt_wd_run;
            wd_irq_ff <= nxt_wd_irq;
            pin_low_ff <= nxt_pin_low;
            rdata_ff <= nxt_rdata;
            rd_addr_q_ff <= reg_addr;
            flag_view_ff <= nxt_flag_view;
            init_ff <= nxt_init;
        end
    end

    // backed-up registers ride through rst; the init cycle picks their value
    always_ff @(posedge sys_clk) begin
        century_ff <= nxt_century;
        control_ff <= nxt_control;
        alarm_ff <= nxt_alarm;
        halt_ff <= nxt_halt;
        hour_ff <= nxt_hour;
        wave_ff <= nxt_wave;
    end

    assign reg_rdata = rdata_ff;
    assign multi_function_pin_out = 1'b0;
    assign multi_function_pin_oe = pin_low_ff;

    wd_res_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_wdog && reg_wdata == 8'h07 && !init_ff |=> wd_cnt_ff == 13'd64)
        else $error("resolution count wrong");
    wd_mult_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_wdog && reg_wdata == 8'h0E && !init_ff |=> wd_cnt_ff == 13'd48)
        else $error("multiplier product wrong");
    wd_expire_a: assert property (@(posedge sys_clk) disable iff (rst)
        wd_run_ff && sixteenth_tick && wd_cnt_ff == 13'd1 && !wr_wdog && !init_ff
        |=> wdf_ff && wd_irq_ff)
        else $error("expiry not flagged");
    wd_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_wdog && reg_wdata == 8'h00 |=> !wd_run_ff && !wd_irq_ff)
        else $error("zero write did not disable");
    flag_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
        rd_flags && !init_ff && !(wd_run_ff && sixteenth_tick) |=> !wdf_ff)
        else $error("flags read did not clear");
    century_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !century_ff[CEN_ENABLE_BIT] && !reg_wr |=> $stable(century_ff[CEN_BIT]))
        else $error("century changed while disabled");
    pin_od_a: assert property (@(posedge sys_clk) disable iff (rst)
        multi_function_pin_oe |-> !multi_function_pin_out)
        else $error("pin driven high");
    pin_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
        $past(pin_low_ff, 2) |-> !pin_sync2_ff)
        else $error("pin not pulled low");
    pin_wave_a: assert property (@(posedge sys_clk) disable iff (rst)
        square_wave_enable && rate_sel != 4'h0 && !init_ff |=> multi_function_pin_oe == $past(~wave_lvl))
        else $error("square wave lost priority");
endmodule

// [rwd_pin_env.sv]
`timescale 1ns/10ps
// far side of the pin: crystal oscillator and pull-up resistor
module rwd_pin_env (
    // oscillator
    output logic osc_clk,
    // pin
    input wire logic pin_oe,
    input wire logic pin_out,
    output logic pin_level
);
    // odd start offset keeps the oscillator out of phase with sys_clk
    initial begin
        osc_clk = 1'b0;
        #37;
        forever #40 osc_clk = ~osc_clk;
    end
    assign pin_level = (pin_oe === 1'b1) ? pin_out : 1'b1;
endmodule

// [rtc_watchdog_sqw_output_pin_test.sv]
`timescale 1ns/10ps
module rtc_watchdog_sqw_output_pin_test;
    import rwd_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic backup_valid = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic century_rollover = 1'b0;
    logic alarm_match = 1'b0;
    logic [7:0] reg_rdata;
    logic osc_clk;
    logic pin_out;
    logic pin_oe;
    logic pin_level;
    int bad_count = 0;
    int checked = 0;
    int n;
    int exp_n;

    always #5 sys_clk = ~sys_clk;

    rwd_watchdog_top i_dut (
        .sys_clk(sys_clk), .rst(rst), .backup_valid(backup_valid), .osc_clk(osc_clk),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .century_rollover(century_rollover),
        .alarm_match(alarm_match), .multi_function_pin_in(pin_level),
        .multi_function_pin_out(pin_out), .multi_function_pin_oe(pin_oe)
    );
    rwd_pin_env i_pin (.osc_clk(osc_clk), .pin_oe(pin_oe), .pin_out(pin_out),
        .pin_level(pin_level));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // inputs always move 1 ns after the rising edge
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        checked++;
        if ((got & m) !== (exp & m)) begin
            bad_count++;
            $display("[FAIL] t=%0t got %0h expected %0h", $time, got & m, exp & m);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("[FAIL] t=%0t got %0h expected %0h to %0h", $time, got, lo, hi);
        end
    endtask

    // idle cycle after the strobe so back-to-back calls never re-raise it in one step
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask

    task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp, input logic [7:0] m);
        reg_addr = addr;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        tick(2);
        check_byte(reg_rdata, exp, m);
    endtask

    task automatic pulse_event(input logic is_alarm);
        alarm_match = is_alarm;
        century_rollover = ~is_alarm;
        tick(1);
        alarm_match = 1'b0;
        century_rollover = 1'b0;
        tick(3);
    endtask

    task automatic count_edges(input int cycles, output int edges);
        logic prev;
        edges = 0;
        prev = pin_level;
        repeat (cycles) begin
            tick(1);
            if (pin_level !== prev) edges++;
            prev = pin_level;
        end
    endtask

    task automatic wait_pin_low(input int limit, output int waited);
        waited = 0;
        while (pin_level !== 1'b0) begin
            tick(1);
            waited++;
            if (waited > limit) begin
                bad_count++;
                $display("[FAIL] t=%0t pin wait ran out after %0h cycles", $time, limit);
                report_and_stop();
            end
        end
    endtask

    initial begin
        tick(2);
        rst = 1'b0;
        tick(2);
        expect_reg(ADDR_WDOG, 8'h00, 8'hFF);
        expect_reg(ADDR_CONTROL, 8'h80, 8'hC0);
        expect_reg(ADDR_ALARM_MONTH, 8'h00, 8'hE0);
        expect_reg(ADDR_HALT, 8'h80, 8'h80);
        expect_reg(ADDR_ALARM_HOUR, 8'h40, 8'h40);
        check_bit(pin_level, 1'b1);
        write_reg(ADDR_CONTROL, 8'h00);
        tick(3);
        check_bit(pin_level, 1'b0);
        check_bit(pin_out, 1'b0);
        // frequency test: 512 Hz is 512 oscillator-scaled sys cycles per period here
        write_reg(ADDR_HALT, 8'h00);
        write_reg(ADDR_CONTROL, 8'h40);
        tick(8);
        count_edges(4096, n);
        check_count(n, 15, 17);
        // watchdog of two sixteenths owns the pin over frequency test
        write_reg(ADDR_WDOG, 8'h0E);
        expect_reg(ADDR_WDOG, 8'h0E, 8'hFF);
        write_reg(ADDR_WDOG, 8'h07);
        write_reg(ADDR_WDOG, 8'h08);
        tick(8);
        count_edges(8000, n);
        check_count(n, 0, 0);
        check_bit(pin_level, 1'b1);
        write_reg(ADDR_WDOG, 8'h08);
        wait_pin_low(34000, n);
        // one sixteenth is 2048 oscillator ticks; tick phase makes the first one short
        check_count(n, 16380, 32800);
        expect_reg(ADDR_FLAGS, 8'h80, 8'h80);
        expect_reg(ADDR_FLAGS, 8'h00, 8'h80);
        check_bit(pin_level, 1'b0);
        write_reg(ADDR_CONTROL, 8'h80);
        write_reg(ADDR_WDOG, 8'h00);
        tick(3);
        check_bit(pin_level, 1'b1);
        count_edges(20000, n);
        check_count(n, 0, 0);
        // alarm interrupt
        write_reg(ADDR_ALARM_MONTH, 8'h80);
        pulse_event(1'b1);
        check_bit(pin_level, 1'b0);
        expect_reg(ADDR_FLAGS, 8'h40, 8'h40);
        tick(3);
        check_bit(pin_level, 1'b1);
        // square wave beats a pending enabled alarm
        pulse_event(1'b1);
        write_reg(ADDR_ALARM_MONTH, 8'hC0);
        for (int code = 1; code < 8; code++) begin
            write_reg(ADDR_WAVE, {code[3:0], 4'hF});
            tick(8);
            count_edges(2048, n);
            exp_n = (code == 1) ? 512 : (512 >> code);
            check_count(n, exp_n - 2, exp_n + 2);
        end
        expect_reg(ADDR_WAVE, 8'h70, 8'hFF);
        write_reg(ADDR_WAVE, 8'h00);
        tick(8);
        count_edges(1024, n);
        check_count(n, 0, 0);
        write_reg(ADDR_WAVE, 8'h60);
        tick(8);
        count_edges(2048, n);
        check_count(n, 6, 10);
        expect_reg(ADDR_FLAGS, 8'h40, 8'h40);
        write_reg(ADDR_ALARM_MONTH, 8'h00);
        tick(8);
        count_edges(2048, n);
        check_count(n, 0, 0);
        check_bit(pin_level, 1'b1);
        // century bit
        write_reg(ADDR_CENTURY, 8'h80);
        pulse_event(1'b0);
        expect_reg(ADDR_CENTURY, 8'hC0, 8'hC0);
        write_reg(ADDR_CENTURY, 8'h40);
        pulse_event(1'b0);
        expect_reg(ADDR_CENTURY, 8'h40, 8'hC0);
        // second power-up with retained backup
        write_reg(ADDR_CONTROL, 8'h40);
        write_reg(ADDR_ALARM_MONTH, 8'hE0);
        write_reg(ADDR_WDOG, 8'h08);
        backup_valid = 1'b1;
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(2);
        expect_reg(ADDR_CONTROL, 8'h00, 8'hC0);
        expect_reg(ADDR_WDOG, 8'h00, 8'hFF);
        expect_reg(ADDR_ALARM_MONTH, 8'hE0, 8'hE0);
        expect_reg(ADDR_HALT, 8'h00, 8'h80);
        expect_reg(ADDR_ALARM_HOUR, 8'h40, 8'h40);
        report_and_stop();
    end
endmodule
